// ### src/asalu_params.svh
// Purpose: Constants for the add and shift datapath.
// Assumes: Included by bare name from the interface, the adder and the core.
// Notes: Definitions only.
`ifndef ASALU_PARAMS_SVH
`define ASALU_PARAMS_SVH
`define ASALU_DATA_W      8
`define ASALU_ADDR_W      7
`define ASALU_PTR_W       16
`define ASALU_OFS_W       6
`define ASALU_NIB_MSB     3
`define ASALU_DATA_MSB    7
`define ASALU_ACC_RST     8'h00
`define ASALU_PTR_RST     16'h0000
`define ASALU_FLAG_RST    1'b0
`define ASALU_WADDR_RST   7'h00
`define ASALU_WDATA_RST   8'h00
`endif

// ### src/asalu_pkg.sv
// Purpose: Types for the add and shift datapath.
// Assumes: Opcode codes other than ASALU_OP_NONE are one-hot.
// Notes: Constants live in the header.
package asalu_pkg;
	typedef enum logic [7:0]
	{
		ASALU_OP_NONE = 8'h00,
		ASALU_OP_PTR  = 8'h01,
		ASALU_OP_ANDL = 8'h02,
		ASALU_OP_ADDL = 8'h04,
		ASALU_OP_ANDF = 8'h08,
		ASALU_OP_ADDF = 8'h10,
		ASALU_OP_ADDC = 8'h20,
		ASALU_OP_ASR  = 8'h40
	} asalu_op_t;
endpackage

// ### src/asalu_flag_if.sv
// Purpose: Carries a computed result and its flags between the datapath modules.
// Assumes: One clock domain.
// Notes: The core drives operands, the flag unit returns results.
`timescale 1ns/10ps
`include "asalu_params.svh"
interface asalu_flag_if;
	logic [`ASALU_DATA_W-1:0] a;
	logic [`ASALU_DATA_W-1:0] b;
	logic                     cin;
	logic                     do_add;
	logic [`ASALU_DATA_W-1:0] sum;
	logic                     cout;
	logic                     dcout;
	logic                     zero;
	modport core (output a, b, cin, do_add, input sum, cout, dcout, zero);
	modport unit (input a, b, cin, do_add, output sum, cout, dcout, zero);
endinterface

// ### src/asalu_adder.sv
// Purpose: Eight-bit adder or AND with carry, nibble carry and zero.
// Assumes: Purely combinational.
// Notes: When do_add is low the result is a AND b.
`timescale 1ns/10ps
`include "asalu_params.svh"
module asalu_adder
(
	asalu_flag_if.unit f
);
	wire [`ASALU_NIB_MSB+1:0]  low_sum;
	wire [`ASALU_DATA_W:0]     full_sum;
	wire [`ASALU_DATA_W-1:0]   result;
	assign low_sum  = {1'b0, f.a[`ASALU_NIB_MSB:0]} + {1'b0, f.b[`ASALU_NIB_MSB:0]}
		+ {4'h0, f.cin};
	assign full_sum = {1'b0, f.a} + {1'b0, f.b} + {8'h00, f.cin};
	assign result   = f.do_add ? full_sum[`ASALU_DATA_W-1:0] : (f.a & f.b);
	assign f.sum    = result;
	assign f.cout   = full_sum[`ASALU_DATA_W];
	assign f.dcout  = low_sum[`ASALU_NIB_MSB+1];
	assign f.zero   = (result == 8'h00);
endmodule

// ### src/asalu_core.sv
// Purpose: Datapath for add, AND, add with carry, shift and pointer offset.
// Assumes: The decoder gives one opcode per cycle with operands valid in that cycle.
// Notes: Results, flags and pointers are registered and appear one cycle later.
// Contract
// - Pointer offset adds signed six-bit literal, flags untouched.
// - Pointer wraps modulo sixty-five thousand five hundred thirty-six.
// - AND literal into accumulator, zero flag only.
// - Add literal into accumulator, updates carry, nibble, zero.
// - AND register, seven-bit address, zero flag only.
// - Destination bit zero accumulator, one register.
// - Add register to accumulator, updates three flags.
// - Arithmetic shift right, bit zero to carry.
// - Add with carry includes current carry flag.
`timescale 1ns/10ps
`include "asalu_params.svh"
module asalu_core
(
	input  wire logic                     clk_sys,
	input  wire logic                     sys_rst,
	input  wire asalu_pkg::asalu_op_t     op,
	input  wire logic [`ASALU_DATA_W-1:0] literal,
	input  wire logic [`ASALU_OFS_W-1:0]  pointer_offset,
	input  wire logic                     pointer_sel,
	input  wire logic [`ASALU_ADDR_W-1:0] reg_addr,
	input  wire logic                     dest_bit,
	input  wire logic [`ASALU_DATA_W-1:0] reg_rdata,
	output logic [`ASALU_DATA_W-1:0]      acc,
	output logic                          carry_flag,
	output logic                          nibble_carry_flag,
	output logic                          zero_flag,
	output logic [`ASALU_PTR_W-1:0]       indirect_pointer0,
	output logic [`ASALU_PTR_W-1:0]       indirect_pointer1,
	output logic                          reg_we,
	output logic [`ASALU_ADDR_W-1:0]      reg_waddr,
	output logic [`ASALU_DATA_W-1:0]      reg_wdata
);
	// The shared adder forms the sum or the AND, with both carries and the zero test.
	asalu_flag_if fif ();

	asalu_adder u_adder
	(
		.f (fif)
	);

	// Sign-extends the offset and adds it; the sum keeps only the pointer width, so it wraps.
	function automatic logic [`ASALU_PTR_W-1:0] asalu_ptr_add
	(
		input logic [`ASALU_PTR_W-1:0] p,
		input logic [`ASALU_OFS_W-1:0] k
	);
		logic [`ASALU_PTR_W-1:0] ext;
		ext = {{(`ASALU_PTR_W-`ASALU_OFS_W){k[`ASALU_OFS_W-1]}}, k};
		return p + ext;
	endfunction

	// Shifts right by one and copies the sign bit back into the top bit.
	function automatic logic [`ASALU_DATA_W-1:0] asalu_asr
	(
		input logic [`ASALU_DATA_W-1:0] v
	);
		return {v[`ASALU_DATA_MSB], v[`ASALU_DATA_MSB:1]};
	endfunction

	// Tells whether a data word is all zeros.
	function automatic logic asalu_is_zero
	(
		input logic [`ASALU_DATA_W-1:0] v
	);
		return (v == {`ASALU_DATA_W{1'b0}});
	endfunction

	// An opcode that is not one of the seven codes selects nothing and leaves accumulator, flags and pointers unchanged; the write strobe goes low.
	wire                     is_ptr;
	wire                     is_andl;
	wire                     is_addl;
	wire                     is_andf;
	wire                     is_addf;
	wire                     is_addc;
	wire                     is_asr;
	wire                     is_lit;
	wire                     is_add;
	wire                     is_logic;
	wire                     is_file;
	wire                     sel_ptr0;
	wire                     sel_ptr1;
	wire                     to_reg;
	wire                     to_acc;
	wire [`ASALU_DATA_W-1:0] shift_res;
	wire                     shift_zero;
	wire [`ASALU_DATA_W-1:0] result;
	wire [`ASALU_DATA_W-1:0] next_acc;
	wire                     next_carry;
	wire                     next_nibble;
	wire                     next_zero;
	wire [`ASALU_PTR_W-1:0]  next_ptr0;
	wire [`ASALU_PTR_W-1:0]  next_ptr1;
	wire                     next_we;
	wire [`ASALU_ADDR_W-1:0] next_waddr;
	wire [`ASALU_DATA_W-1:0] next_wdata;

	assign is_ptr   = (op == asalu_pkg::ASALU_OP_PTR);
	assign is_andl  = (op == asalu_pkg::ASALU_OP_ANDL);
	assign is_addl  = (op == asalu_pkg::ASALU_OP_ADDL);
	assign is_andf  = (op == asalu_pkg::ASALU_OP_ANDF);
	assign is_addf  = (op == asalu_pkg::ASALU_OP_ADDF);
	assign is_addc  = (op == asalu_pkg::ASALU_OP_ADDC);
	assign is_asr   = (op == asalu_pkg::ASALU_OP_ASR);
	assign is_lit   = is_andl | is_addl;
	assign is_add   = is_addl | is_addf | is_addc;
	assign is_logic = is_andl | is_andf;
	assign is_file  = is_andf | is_addf | is_addc | is_asr;
	assign sel_ptr0 = is_ptr & ~pointer_sel;
	assign sel_ptr1 = is_ptr & pointer_sel;
	assign to_reg   = is_file & dest_bit;
	assign to_acc   = is_lit | (is_file & ~dest_bit);

	// The adder always sees the accumulator; the second operand is the literal or the register.
	assign fif.a      = acc;
	assign fif.b      = is_lit ? literal : reg_rdata;
	assign fif.cin    = is_addc & carry_flag;
	assign fif.do_add = is_add;

	assign shift_res  = asalu_asr(reg_rdata);
	assign shift_zero = asalu_is_zero(shift_res);
	assign result     = is_asr ? shift_res : fif.sum;

	// A flag that the operation does not name keeps its value.
	assign next_acc    = to_acc ? result : acc;
	assign next_carry  = is_add ? fif.cout : (is_asr ? reg_rdata[0] : carry_flag);
	assign next_nibble = is_add ? fif.dcout : nibble_carry_flag;
	assign next_zero   = is_asr ? shift_zero
		: ((is_add | is_logic) ? fif.zero : zero_flag);
	assign next_ptr0   = sel_ptr0 ? asalu_ptr_add(indirect_pointer0, pointer_offset)
		: indirect_pointer0;
	assign next_ptr1   = sel_ptr1 ? asalu_ptr_add(indirect_pointer1, pointer_offset)
		: indirect_pointer1;
	assign next_we     = to_reg;
	assign next_waddr  = reg_addr;
	assign next_wdata  = result;

	// The accumulator and each flag have their own short register process.
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			acc <= `ASALU_ACC_RST;
		end
		else
		begin
			acc <= next_acc;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			carry_flag <= `ASALU_FLAG_RST;
		end
		else
		begin
			carry_flag <= next_carry;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			nibble_carry_flag <= `ASALU_FLAG_RST;
		end
		else
		begin
			nibble_carry_flag <= next_nibble;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			zero_flag <= `ASALU_FLAG_RST;
		end
		else
		begin
			zero_flag <= next_zero;
		end
	end

	// The two pointers move only on their own selection.
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			indirect_pointer0 <= `ASALU_PTR_RST;
		end
		else
		begin
			indirect_pointer0 <= next_ptr0;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			indirect_pointer1 <= `ASALU_PTR_RST;
		end
		else
		begin
			indirect_pointer1 <= next_ptr1;
		end
	end

	// Address and data follow every cycle; they matter only while the strobe is high.
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			reg_we    <= 1'b0;
			reg_waddr <= `ASALU_WADDR_RST;
			reg_wdata <= `ASALU_WDATA_RST;
		end
		else
		begin
			reg_we    <= next_we;
			reg_waddr <= next_waddr;
			reg_wdata <= next_wdata;
		end
	end
endmodule

// ### testbench/asalu_monitor.sv
// Purpose: Port assertions for the add and shift datapath.
// Assumes: One clock domain, reset active high.
// Notes: Bound to asalu_core at the foot of this file.
`timescale 1ns/10ps
module asalu_monitor
(
	input wire logic                 clk_sys,
	input wire logic                 sys_rst,
	input wire asalu_pkg::asalu_op_t op,
	input wire logic [7:0]           literal,
	input wire logic [5:0]           pointer_offset,
	input wire logic                 pointer_sel,
	input wire logic                 dest_bit,
	input wire logic [7:0]           reg_rdata,
	input logic [7:0]                acc,
	input logic                      carry_flag,
	input logic                      nibble_carry_flag,
	input logic                      zero_flag,
	input logic [15:0]               indirect_pointer0,
	input logic                      reg_we,
	input logic [7:0]                reg_wdata
);
	wire logic [15:0] n0 = indirect_pointer0 + {{10{pointer_offset[5]}}, pointer_offset};
	wire logic [8:0]  sl = acc + literal;
	wire logic [8:0]  sr = acc + reg_rdata;
	wire logic [8:0]  sf = acc + reg_rdata + carry_flag;
	wire logic [4:0]  hf = acc[3:0] + reg_rdata[3:0] + carry_flag;
	wire logic        hc = hf[4];
	wire logic [8:0]  sh = {reg_rdata[0], reg_rdata[7], reg_rdata[7:1]};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	a_ptr_flags:
	assert property (op[0] |=> $stable({carry_flag, nibble_carry_flag, zero_flag}))
		else $error("flag moved");
	a_ptr_wrap:
	assert property (op[0] && !pointer_sel |=> indirect_pointer0 == $past(n0))
		else $error("bad pointer");
	a_andl_zero:
	assert property (op[1] |=> acc == ($past(acc) & $past(literal)) && zero_flag == (acc == 8'h00)
		&& $stable(carry_flag)) else $error("bad and literal");
	a_addl_sum:
	assert property (op[2] |=> {carry_flag, acc} == $past(sl)) else $error("bad add literal");
	a_andf_back:
	assert property (op[3] && dest_bit |=> reg_we && $stable(acc)
		&& reg_wdata == ($past(acc) & $past(reg_rdata))) else $error("bad write back");
	a_addf_acc:
	assert property (op[4] && !dest_bit |=> {carry_flag, acc} == $past(sr) && !reg_we)
		else $error("bad add");
	a_asr_shift:
	assert property (op[6] && !dest_bit |=> {carry_flag, acc} == $past(sh)
		&& zero_flag == (acc == 8'h00)) else $error("bad shift");
	a_addc_sum:
	assert property (op[5] && !dest_bit |=> {carry_flag, acc} == $past(sf)
		&& nibble_carry_flag == $past(hc)) else $error("bad add with carry");
endmodule
bind asalu_core asalu_monitor asalu_monitor_i (.clk_sys, .sys_rst, .op, .literal, .pointer_offset,
	.pointer_sel, .dest_bit, .reg_rdata, .acc, .carry_flag, .nibble_carry_flag, .zero_flag,
	.indirect_pointer0, .reg_we, .reg_wdata);

// ### testbench/tb_top.sv
// Purpose: Random and corner checks of the add and shift datapath.
// Assumes: Outputs change one cycle after the op.
// Notes: The first two ops walk pointer zero below zero and back.
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
	$display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb_top;
	asalu_pkg::asalu_op_t op;
	logic [7:0]  literal, reg_rdata, acc, reg_wdata, ea, ewd, b, r;
	logic [6:0]  reg_addr, reg_waddr, ewa;
	logic [5:0]  pointer_offset;
	logic [15:0] indirect_pointer0, indirect_pointer1, ep0, ep1, k;
	logic [9:0]  t;
	logic        clk_sys = 0, sys_rst = 1, pointer_sel, dest_bit, ec, edc, ez, ewe;
	logic        carry_flag, nibble_carry_flag, zero_flag, reg_we;
	int          failures, compares;
	always #50 clk_sys = ~clk_sys;
	asalu_core asalu_core_i (.clk_sys, .sys_rst, .op, .literal, .pointer_offset, .pointer_sel,
		.reg_addr, .dest_bit, .reg_rdata, .acc, .carry_flag, .nibble_carry_flag, .zero_flag,
		.indirect_pointer0, .indirect_pointer1, .reg_we, .reg_waddr, .reg_wdata);
	function automatic logic [9:0] add3(input logic [7:0] a, x, input logic ci);
		logic [4:0] n;
		n = a[3:0] + x[3:0] + ci;
		add3 = {n[4], {1'b0, a} + x + ci};
	endfunction
	task wrap_up;
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#60000 failures++;
		wrap_up;
	end
	initial
	begin
		void'($urandom(32'h25C0));
		{op, literal, pointer_offset, pointer_sel, reg_addr, dest_bit, reg_rdata} = '0;
		{ea, ec, edc, ez, ep0, ep1, ewe, ewa, ewd} = '0;
		repeat (8) @(posedge clk_sys);
		#10 sys_rst = 0;
		for (int i = 0; i < 400; i++)
		begin
			@(posedge clk_sys);
			#10;
			`CHK({acc, carry_flag, nibble_carry_flag, zero_flag}, {ea, ec, edc, ez})
			`CHK(reg_we, ewe)
			`CHK({indirect_pointer0, indirect_pointer1}, {ep0, ep1})
			if (ewe) `CHK({reg_waddr, reg_wdata}, {ewa, ewd})
			op = asalu_pkg::asalu_op_t'(8'h01 << (i < 3 ? 0 : $urandom % 8));
			{literal, pointer_offset, pointer_sel, reg_addr, dest_bit, reg_rdata} = $urandom;
			if (i < 2) {pointer_sel, pointer_offset} = i ? 7'h01 : 7'h3F;
			b = (op[1] | op[2]) ? literal : reg_rdata;
			t = add3(ea, b, op[5] & ec);
			r = op[6] ? {b[7], b[7:1]} : (op[1] | op[3]) ? ea & b : t[7:0];
			k = {{10{pointer_offset[5]}}, pointer_offset};
			ewe = 0;
			if (op[0] && pointer_sel) ep1 += k;
			if (op[0] && !pointer_sel) ep0 += k;
			if (op[2] | op[4] | op[5]) {edc, ec} = t[9:8];
			if (op[6]) ec = b[0];
			if (op[6:1] != 0) ez = r == 8'h00;
			if (op[6:3] != 0 && dest_bit) {ewe, ewa, ewd} = {1'b1, reg_addr, r};
			else if (op[6:1] != 0) ea = r;
		end
		wrap_up;
	end
endmodule
